// file: hw/dcsq_aux_drv.sv
`timescale 1ns/1ps
`default_nettype none
module dcsq_aux_drv
(
  input  wire logic level,
  input  wire logic gating,
  input  wire logic open_drain,
  input  wire logic seq_on,
  output logic      pin_out,
  output logic      pin_oe
);

  logic want;

  // Level bit alone, or level AND the sequenced enable
  assign want    = gating ? (level & seq_on) : level;
  // Open-drain only pulls low; push-pull always drives
  assign pin_out = open_drain ? 1'b0 : want;
  assign pin_oe  = open_drain ? ~want : 1'b1;

endmodule
`default_nettype wire

// file: hw/dcsq_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dcsq_channel
  import dcsq_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  dcsq_seq_if.ch          ctl,
  input  wire logic [7:0] delays,
  output logic            on
);

  typedef struct packed {
    dcsq_state_e st;
    logic [4:0]  cnt;
    logic        on;
  } dcsq_ch_s;

  dcsq_ch_s s_r;
  dcsq_ch_s s_nxt;
  logic [4:0] up_t;
  logic [4:0] dn_t;

  assign up_t = dcsq_ticks(delays[3:0], ctl.up_long);
  assign dn_t = dcsq_ticks(delays[7:4], ctl.dn_long);
  assign on   = s_r.on;

  // ==========================================================
  // Sequencing state machine
  always_comb
  begin
    s_nxt = s_r;
    if (ctl.en_rise)
    begin
      s_nxt.cnt = up_t;
      s_nxt.st  = (up_t == 5'h00) ? DCSQ_ON : DCSQ_WAIT_UP;
    end
    else if (ctl.en_fall)
    begin
      s_nxt.cnt = dn_t;
      s_nxt.st  = (dn_t == 5'h00) ? DCSQ_OFF : DCSQ_WAIT_DN;
    end
    else
    begin
      unique case (s_r.st)
        DCSQ_OFF, DCSQ_ON:
          s_nxt.cnt = 5'h00;
        DCSQ_WAIT_UP:
          if (ctl.tick)
          begin
            s_nxt.cnt = s_r.cnt - 5'h01;
            if (s_r.cnt == 5'h01)
              s_nxt.st = DCSQ_ON;
          end
        DCSQ_WAIT_DN:
          if (ctl.tick)
          begin
            s_nxt.cnt = s_r.cnt - 5'h01;
            if (s_r.cnt == 5'h01)
              s_nxt.st = DCSQ_OFF;
          end
      endcase
    end
    // Output holds through either wait and moves only on arrival
    if (s_nxt.st == DCSQ_ON)
      s_nxt.on = 1'b1;
    else if (s_nxt.st == DCSQ_OFF)
      s_nxt.on = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      s_r <= '{st: DCSQ_OFF, cnt: 5'h00, on: 1'b0};
    else
      s_r <= s_nxt;
  end

endmodule
`default_nettype wire

// file: hw/dcsq_pkg.sv
// Summary of operation
// - Code 0x4C is 1 V, 5 mV steps
// - Codes 0x9E to 0xFF step 20 mV
// - Converter 0 code register at 0x06
// - Converter 1 has own code register
// - Converter start waits low delay nibble
// - Converter stop waits high delay nibble
// - Delay unit 0.5 ms, or 1 ms
// - Output A rises after low nibble delay
// - Output A falls after high nibble delay
// - Output B rises after low nibble delay
// - Output B falls after high nibble delay
// - Bit 6 selects output B open-drain
// - Bit 5 gates output B with enable
// - Bit 4 is output B level
// - Bit 2 selects output A open-drain
// - Bit 1 gates output A with enable
// - Bit 0 is output A level
// - Config bit 6 selects startup range
// - Config bit 5 selects shutdown range
`default_nettype none
package dcsq_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CONV0_VCODE = 8'h06;
  localparam logic [7:0] OFS_CONV1_VCODE = 8'h07;
  localparam logic [7:0] OFS_CONV0_DLY   = 8'h0C;
  localparam logic [7:0] OFS_CONV1_DLY   = 8'h0D;
  localparam logic [7:0] OFS_AUXA_DLY    = 8'h10;
  localparam logic [7:0] OFS_AUXB_DLY    = 8'h11;
  localparam logic [7:0] OFS_AUX_CTRL    = 8'h12;
  localparam logic [7:0] OFS_CONFIG      = 8'h13;

  // ==========================================================
  // Field positions and reset values
  localparam int         CTL_B_OD      = 6;
  localparam int         CTL_B_GATE    = 5;
  localparam int         CTL_B_LEVEL   = 4;
  localparam int         CTL_A_OD      = 2;
  localparam int         CTL_A_GATE    = 1;
  localparam int         CTL_A_LEVEL   = 0;
  localparam logic [7:0] CTL_WR_MASK   = 8'h77;
  localparam int         CFG_UP_RANGE  = 6;
  localparam int         CFG_DN_RANGE  = 5;
  localparam logic [7:0] RST_VCODE     = 8'h4C;
  localparam logic [7:0] RST_ZERO      = 8'h00;

  // ==========================================================
  // Voltage code encoding
  localparam logic [7:0]  VC_FINE_LO   = 8'h4C;
  localparam logic [7:0]  VC_FINE_HI   = 8'h9D;
  localparam logic [7:0]  VC_COARSE_LO = 8'h9E;
  localparam logic [11:0] MV_FINE_BASE = 12'h3E8;
  localparam logic [11:0] MV_COARSE_BASE = 12'h58C;
  localparam logic [11:0] MV_FINE_STEP = 12'h005;
  localparam logic [11:0] MV_COARSE_STEP = 12'h014;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned DLY_UNIT_NS   = 500000;
  localparam int unsigned DLY_UNIT_CYC  = DLY_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    DCSQ_OFF     = 2'b00,
    DCSQ_WAIT_UP = 2'b01,
    DCSQ_ON      = 2'b11,
    DCSQ_WAIT_DN = 2'b10
  } dcsq_state_e;

  // Code to millivolts; unsupported codes give zero
  function automatic logic [11:0] dcsq_code_mv(input logic [7:0] code);
    logic [11:0] c;
    c = {4'h0, code};
    if (code < VC_FINE_LO)
      dcsq_code_mv = 12'h000;
    else if (code <= VC_FINE_HI)
      dcsq_code_mv = MV_FINE_BASE
                     + 12'((c - {4'h0, VC_FINE_LO}) * MV_FINE_STEP);
    else
      dcsq_code_mv = MV_COARSE_BASE
                     + 12'((c - {4'h0, VC_COARSE_LO}) * MV_COARSE_STEP);
  endfunction

  // Delay code to count of half-millisecond ticks
  function automatic logic [4:0] dcsq_ticks(input logic [3:0] code,
                                            input logic       long_unit);
    dcsq_ticks = long_unit ? {code, 1'b0} : {1'b0, code};
  endfunction

endpackage
`default_nettype wire

// file: hw/dcsq_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcsq_seq_if;
  logic tick;
  logic en_rise;
  logic en_fall;
  logic up_long;
  logic dn_long;
  modport src (output tick, output en_rise, output en_fall,
               output up_long, output dn_long);
  modport ch  (input tick, input en_rise, input en_fall,
               input up_long, input dn_long);
endinterface
`default_nettype wire

// file: hw/dcsq_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcsq_top
  import dcsq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = DLY_UNIT_CYC
)
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        en_pin,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic      [7:0]  conv0_voltage_code,
  output logic      [7:0]  conv1_voltage_code,
  output logic      [11:0] conv0_target_mv,
  output logic      [11:0] conv1_target_mv,
  output logic             conv0_run,
  output logic             conv1_run,
  output logic             aux_output_a,
  output logic             aux_output_a_oe,
  output logic             aux_output_b,
  output logic             aux_output_b_oe
);

  typedef struct packed {
    logic [7:0]  v0;
    logic [7:0]  v1;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [7:0]  da;
    logic [7:0]  db;
    logic [7:0]  ctl;
    logic [7:0]  cfg;
    logic        en_d;
    logic [15:0] pre;
    logic        tick;
    logic [7:0]  rdata;
    logic [11:0] mv0;
    logic [11:0] mv1;
    logic        a_out;
    logic        a_oe;
    logic        b_out;
    logic        b_oe;
  } dcsq_top_s;

  dcsq_top_s  s_r;
  dcsq_top_s  s_nxt;
  dcsq_seq_if seq ();
  logic       c0_on;
  logic       c1_on;
  logic       a_on;
  logic       b_on;
  logic       a_pin;
  logic       a_pin_oe;
  logic       b_pin;
  logic       b_pin_oe;
  logic       rise;
  logic       fall;

  // ==========================================================
  // Enable edges and shared delay timebase
  assign rise        = en_pin & ~s_r.en_d;
  assign fall        = ~en_pin & s_r.en_d;
  assign seq.tick    = s_r.tick;
  assign seq.en_rise = rise;
  assign seq.en_fall = fall;
  assign seq.up_long = s_r.cfg[CFG_UP_RANGE];
  assign seq.dn_long = s_r.cfg[CFG_DN_RANGE];

  // ==========================================================
  // Sequenced channels
  dcsq_channel u_conv0 (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ctl     (seq),
    .delays  (s_r.d0),
    .on      (c0_on)
  );

  dcsq_channel u_conv1 (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ctl     (seq),
    .delays  (s_r.d1),
    .on      (c1_on)
  );

  dcsq_channel u_auxa (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ctl     (seq),
    .delays  (s_r.da),
    .on      (a_on)
  );

  dcsq_channel u_auxb (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ctl     (seq),
    .delays  (s_r.db),
    .on      (b_on)
  );

  // ==========================================================
  // Auxiliary pin drivers
  dcsq_aux_drv u_drv_a (
    .level      (s_r.ctl[CTL_A_LEVEL]),
    .gating     (s_r.ctl[CTL_A_GATE]),
    .open_drain (s_r.ctl[CTL_A_OD]),
    .seq_on     (a_on),
    .pin_out    (a_pin),
    .pin_oe     (a_pin_oe)
  );

  dcsq_aux_drv u_drv_b (
    .level      (s_r.ctl[CTL_B_LEVEL]),
    .gating     (s_r.ctl[CTL_B_GATE]),
    .open_drain (s_r.ctl[CTL_B_OD]),
    .seq_on     (b_on),
    .pin_out    (b_pin),
    .pin_oe     (b_pin_oe)
  );

  // ==========================================================
  // Register file and next state
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.en_d = en_pin;
    s_nxt.tick = 1'b0;
    if (rise || fall)
      s_nxt.pre = 16'h0000;
    else if (s_r.pre == 16'(TICK_CYCLES - 1))
    begin
      s_nxt.pre  = 16'h0000;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.pre = s_r.pre + 16'h0001;

    if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_CONV0_VCODE: s_nxt.v0  = reg_wdata;
        OFS_CONV1_VCODE: s_nxt.v1  = reg_wdata;
        OFS_CONV0_DLY:   s_nxt.d0  = reg_wdata;
        OFS_CONV1_DLY:   s_nxt.d1  = reg_wdata;
        OFS_AUXA_DLY:    s_nxt.da  = reg_wdata;
        OFS_AUXB_DLY:    s_nxt.db  = reg_wdata;
        OFS_AUX_CTRL:    s_nxt.ctl = reg_wdata & CTL_WR_MASK;
        OFS_CONFIG:      s_nxt.cfg = reg_wdata;
        default:         s_nxt.v0  = s_r.v0;
      endcase
    end

    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_CONV0_VCODE: s_nxt.rdata = s_r.v0;
        OFS_CONV1_VCODE: s_nxt.rdata = s_r.v1;
        OFS_CONV0_DLY:   s_nxt.rdata = s_r.d0;
        OFS_CONV1_DLY:   s_nxt.rdata = s_r.d1;
        OFS_AUXA_DLY:    s_nxt.rdata = s_r.da;
        OFS_AUXB_DLY:    s_nxt.rdata = s_r.db;
        OFS_AUX_CTRL:    s_nxt.rdata = s_r.ctl & CTL_WR_MASK;
        OFS_CONFIG:      s_nxt.rdata = s_r.cfg;
        default:         s_nxt.rdata = RST_ZERO;
      endcase
    end

    s_nxt.mv0   = dcsq_code_mv(s_r.v0);
    s_nxt.mv1   = dcsq_code_mv(s_r.v1);
    s_nxt.a_out = a_pin;
    s_nxt.a_oe  = a_pin_oe;
    s_nxt.b_out = b_pin;
    s_nxt.b_oe  = b_pin_oe;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r       <= '0;
      s_r.v0    <= RST_VCODE;
      s_r.v1    <= RST_VCODE;
      s_r.mv0   <= MV_FINE_BASE;
      s_r.mv1   <= MV_FINE_BASE;
      s_r.a_oe  <= 1'b1;
      s_r.b_oe  <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // Outputs
  assign reg_rdata          = s_r.rdata;
  assign conv0_voltage_code = s_r.v0;
  assign conv1_voltage_code = s_r.v1;
  assign conv0_target_mv    = s_r.mv0;
  assign conv1_target_mv    = s_r.mv1;
  assign conv0_run          = c0_on;
  assign conv1_run          = c1_on;
  assign aux_output_a       = s_r.a_out;
  assign aux_output_a_oe    = s_r.a_oe;
  assign aux_output_b       = s_r.b_out;
  assign aux_output_b_oe    = s_r.b_oe;

endmodule
`default_nettype wire

// file: tb/dcsq_host.sv
`timescale 1ns/1ps
`default_nettype none
module dcsq_host
  import dcsq_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            en_pin,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // ==========
  // Host side of the strobe port and enable pin
  initial
  begin
    {en_pin, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= ((a == OFS_CONV0_VCODE || a == OFS_CONV1_VCODE)
                  && d < 8'h4C) ? 8'h4C : d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 d = reg_rdata;
  endtask

  task automatic set_en(input logic v);
    @(posedge sys_clk);
    en_pin <= v;
  endtask
endmodule
`default_nettype wire

// file: tb/dcsq_props.sv
`timescale 1ns/1ps
`default_nettype none
module dcsq_props
  import dcsq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = DLY_UNIT_CYC
)
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        en_pin,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  conv0_voltage_code,
  input wire logic [7:0]  conv1_voltage_code,
  input wire logic [11:0] conv0_target_mv,
  input wire logic [11:0] conv1_target_mv,
  input wire logic        conv0_run,
  input wire logic        conv1_run,
  input wire logic        aux_output_a,
  input wire logic        aux_output_a_oe,
  input wire logic        aux_output_b,
  input wire logic        aux_output_b_oe
);
  // ==========
  // Port checks
  logic hit0;
  logic hit1;
  assign hit0 = reg_wr && reg_addr == 8'h06;
  assign hit1 = reg_wr && reg_addr == OFS_CONV1_VCODE;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_code0_write: assert property (
    $changed(conv0_voltage_code) |-> $past(hit0) || $past(hit0, 2))
    else $error("converter 0 code changed without a write");
  a_code1_write: assert property (
    $changed(conv1_voltage_code) |-> $past(hit1) || $past(hit1, 2))
    else $error("converter 1 code changed without a write");
  a_mv_fine: assert property (
    $stable(conv0_voltage_code) && conv0_voltage_code inside {[8'h4C:8'h9D]}
    |-> conv0_target_mv == 12'h3E8 + (conv0_voltage_code - 8'h4C) * 12'h005)
    else $error("fine segment target wrong");
  a_mv_coarse: assert property (
    $stable(conv1_voltage_code) && conv1_voltage_code >= 8'h9E
    |-> conv1_target_mv == 12'h58C + (conv1_voltage_code - 8'h9E) * 12'h014)
    else $error("coarse segment target wrong");
  a_run_rise: assert property (
    $rose(conv0_run) |-> $past(en_pin) || $past(en_pin, 2))
    else $error("converter started without enable");
  a_run_fall: assert property (
    $fell(conv1_run) |-> !$past(en_pin) || !$past(en_pin, 2))
    else $error("converter stopped with enable high");
  a_od_a_low: assert property (
    !aux_output_a_oe |-> !aux_output_a)
    else $error("output a released but driving high");
  a_od_b_low: assert property (
    !aux_output_b_oe |-> !aux_output_b)
    else $error("output b released but driving high");

  c_run0: cover property ($rose(conv0_run));
  c_run1_off: cover property ($fell(conv1_run));
  c_od_b: cover property (!aux_output_b_oe);
endmodule

bind dcsq_top dcsq_props #(.TICK_CYCLES(TICK_CYCLES)) props (.sys_clk,
  .rstn, .en_pin, .reg_addr, .reg_wr, .conv0_voltage_code,
  .conv1_voltage_code, .conv0_target_mv, .conv1_target_mv, .conv0_run,
  .conv1_run, .aux_output_a, .aux_output_a_oe, .aux_output_b,
  .aux_output_b_oe);
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dcsq_pkg::*;
;
  localparam int T = 4;
  logic        sys_clk, rstn, en_pin, reg_wr, reg_rd, conv0_run, conv1_run;
  logic        aux_output_a, aux_output_a_oe, aux_output_b, aux_output_b_oe;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, c;
  logic [7:0]  conv0_voltage_code, conv1_voltage_code;
  logic [11:0] conv0_target_mv, conv1_target_mv;
  logic [7:0]  tbl [4] = '{8'h4C, 8'h9D, 8'h9E, 8'hFF};
  logic [7:0]  dly_ofs [4] = '{8'h0C, 8'h0D, 8'h10, 8'h11};
  int          num_errors, samples_checked;
  int          mreg [256];

  dcsq_top #(.TICK_CYCLES(T)) dut (.sys_clk, .rstn, .en_pin, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv0_voltage_code,
    .conv1_voltage_code, .conv0_target_mv, .conv1_target_mv, .conv0_run,
    .conv1_run, .aux_output_a, .aux_output_a_oe, .aux_output_b,
    .aux_output_b_oe);
  dcsq_host host (.sys_clk, .reg_rdata, .en_pin, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ==========
  // Reference model and helpers
  function automatic int mv(int x);
    return x < 76 ? 0 : x <= 157 ? 1000 + (x - 76) * 5 : 1420 + (x - 158) * 20;
  endfunction

  function automatic logic [1:0] pin(int ctl, int s);
    logic want;
    want = ctl[s] & ~ctl[s+1];
    return ctl[s+2] ? {1'b0, ~want} : {want, 1'b1};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a inside {8'h06, 8'h07, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13})
      mreg[a] = a == 8'h12 ? d & 8'h77 : d;
  endtask

  task automatic rall;
    logic [7:0] d;
    for (int a = 0; a < 'h21; a++)
    begin
      host.rd(8'(a), d);
      check(d, mreg[a]);
    end
  endtask

  // Times each output's change after an enable edge
  task automatic seq(input logic v, input bit cancel);
    int t[4], e[4], n, u;
    logic [3:0] s0, s;
    #1;
    s0 = {aux_output_b, aux_output_a, conv1_run, conv0_run};
    foreach (e[j])
    begin
      n = v ? mreg[dly_ofs[j]] & 15 : mreg[dly_ofs[j]] >> 4;
      u = mreg[8'h13][v ? 6 : 5] ? 2 : 1;
      e[j] = cancel ? -1 : n == 0 ? 1 : n * u * T + 1 + (j > 1);
      t[j] = -1;
    end
    host.set_en(v);
    @(posedge sys_clk);
    for (int i = 1; i < 200; i++)
    begin
      @(posedge sys_clk);
      #1;
      s = {aux_output_b, aux_output_a, conv1_run, conv0_run};
      foreach (t[j])
        if (t[j] < 0 && s[j] !== s0[j])
          t[j] = i;
    end
    foreach (t[j])
      check(t[j], e[j]);
  endtask

  // ==========
  // Main sequence
  initial
  begin
    num_errors = 0;
    samples_checked = 0;
    rstn = 1'b0;
    void'($urandom(84643));
    foreach (mreg[i])
      mreg[i] = 0;
    mreg[6] = 'h4C;
    mreg[7] = 'h4C;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    rall();
    for (int k = 0; k < 12; k++)
    begin
      c = k < 4 ? tbl[k] : 8'($urandom_range(255, 76));
      w(8'h06, c);
      c = k < 4 ? tbl[3-k] : 8'($urandom_range(255, 76));
      w(8'h07, c);
      w(8'h12, 8'($urandom));
      foreach (dly_ofs[j])
        w(dly_ofs[j], 8'($urandom));
      w(8'h13, 8'($urandom));
      w(8'h20, 8'($urandom));
      repeat (3) @(posedge sys_clk);
      #1;
      check(conv0_voltage_code, mreg[6]);
      check(conv1_voltage_code, mreg[7]);
      check(conv0_target_mv, mv(mreg[6]));
      check(conv1_target_mv, mv(mreg[7]));
      check({aux_output_a, aux_output_a_oe, aux_output_b, aux_output_b_oe},
            {pin(mreg[18], 0), pin(mreg[18], 4)});
    end
    rall();
    for (int k = 0; k < 6; k++)
    begin
      foreach (dly_ofs[j])
        w(dly_ofs[j], k == 0 ? 8'h00 : 8'($urandom) | 8'h01);
      w(8'h13, 8'($urandom));
      w(8'h12, 8'h33);
      if (k == 5)
      begin
        host.set_en(1'b1);
        repeat (2) @(posedge sys_clk);
        seq(1'b0, 1'b1);
      end
      else
      begin
        repeat (3) @(posedge sys_clk);
        seq(1'b1, 1'b0);
        seq(1'b0, 1'b0);
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
